//--- shared/psrc_pkg.sv
// shared constants and carriers of the pll, system mode and rtc prescaler slice
// assumes a 32-bit apb slave with byte offsets in the low address bits
package psrc_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CLOCK_CONTROL_CFG = 8'h00;
  localparam logic [7:0] OFS_REGULATOR_CONTROL = 8'h04;
  localparam logic [7:0] OFS_CLOCK_FLAGS       = 8'h08;
  localparam logic [7:0] OFS_PLL_CONFIG        = 8'h18;
  localparam logic [7:0] OFS_SYSTEM_MODE       = 8'h20;
  localparam logic [7:0] OFS_RTC_PRESCALE      = 8'h28;

  // field positions
  localparam int BIT_HALT_PERMIT     = 11;
  localparam int BIT_SOFT_RESET_HALT = 3;
  localparam int BIT_REGULATOR_READY = 2;
  localparam int BIT_INPUT_HALVING   = 15;
  localparam int BIT_PLL_LOCKED      = 1;
  localparam int BIT_CLOCK_SOURCE    = 0;
  localparam int BIT_FREE_RUN        = 7;
  localparam int BIT_REF_RANGE       = 6;
  localparam int POS_MULT            = 4;
  localparam int POS_DIV             = 0;
  localparam int BIT_HALT_REQUEST    = 1;
  localparam int BIT_WAIT_FOR_IRQ    = 0;
  localparam int POS_RTC_CODE        = 0;

  // reset values
  localparam logic [31:0] PLL_CONFIG_RST   = 32'h0000_0007;
  localparam logic [31:0] SYSTEM_MODE_RST  = 32'h0000_0001;
  localparam logic [31:0] RTC_PRESCALE_RST = 32'h0000_000f;

  // encodings
  localparam logic [2:0] DIV_PLL_OFF    = 3'h7;
  localparam logic [3:0] RTC_STOP_CODE  = 4'ha;
  localparam logic [1:0] MULT_CODE_X28  = 2'h2;
  localparam logic [1:0] MULT_CODE_X20  = 2'h0;
  localparam logic [1:0] MULT_CODE_X16  = 2'h3;
  localparam logic [1:0] MULT_CODE_X12  = 2'h1;
  localparam logic [4:0] MULT_X28       = 5'h1c;
  localparam logic [4:0] MULT_X20       = 5'h14;
  localparam logic [4:0] MULT_X16       = 5'h10;
  localparam logic [4:0] MULT_X12       = 5'h0c;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } psrc_apb_req_t;

  typedef struct packed {
    logic       pll_enable;
    logic       free_run;
    logic       ref_range;
    logic       ref_halve;
    logic [4:0] mult;
    logic [2:0] div_code;
    logic       mclk_from_pll;
  } psrc_pll_ctrl_t;

endpackage : psrc_pkg

//--- src/psrc_mclk_div.sv
// main clock enable generator: one pulse every div_code+1 cycles of the raw pll clock
// assumes the raw pll clock is represented by the core clock of this domain
module psrc_mclk_div import psrc_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [2:0] div_code,
  // result
  output logic            tick
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } psrc_div_state_t;

  psrc_div_state_t s_reg;
  psrc_div_state_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = 3'h0;
    end else if (s_reg.cnt >= div_code) begin
      s_next.cnt  = 3'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule // psrc_mclk_div

//--- src/psrc_rtc_presc.sv
// rtc prescaler: divides the oscillator pin by 2^(code+1), codes 10..15 stop it
// assumes osc_pin is asynchronous and well below half the core clock rate
module psrc_rtc_presc import psrc_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // oscillator pin and setting
  input  wire logic       osc_pin,
  input  wire logic [3:0] code,
  // divided clock
  output logic            rtc_clk
);

  typedef struct packed {
    logic [2:0] sync;
    logic [3:0] code_q;
    logic [8:0] cnt;
    logic       out;
  } psrc_presc_state_t;

  psrc_presc_state_t s_reg;
  psrc_presc_state_t s_next;
  logic              osc_rise;
  logic [8:0]        limit;

  // sync[0] feeds only sync[1]; the edge is taken between sync[1] and sync[2]
  assign osc_rise = s_reg.sync[1] & ~s_reg.sync[2];
  assign limit    = 9'((10'h1 << code) - 10'h1);

  always_comb begin
    s_next        = s_reg;
    s_next.sync   = {s_reg.sync[1:0], osc_pin};
    s_next.code_q = code;
    if (code != s_reg.code_q) begin
      s_next.cnt = 9'h0;
      s_next.out = 1'b0;
    end else if (code >= RTC_STOP_CODE) begin
      s_next.cnt = 9'h0;
      s_next.out = 1'b0;
    end else if (osc_rise) begin
      if (s_reg.cnt >= limit) begin
        s_next.cnt = 9'h0;
        s_next.out = ~s_reg.out;
      end else begin
        s_next.cnt = s_reg.cnt + 9'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg        <= '0;
      s_reg.code_q <= RTC_PRESCALE_RST[3:0];
    end else begin
      s_reg <= s_next;
    end
  end

  assign rtc_clk = s_reg.out;

endmodule // psrc_rtc_presc

//--- src/psrc_ctrl.sv
// apb register slice for pll setup, system mode and rtc prescaling
// assumes apb3 signalling on CORE_CLK; lock, regulator and oscillator inputs are asynchronous
// What this block does
// - reserved bits of pll, system mode and rtc registers read zero
// - without free run, pll follows only multiplier and divider fields
// - free run with divider 111 keeps pll on as slow back-up clock
// - in free run, pll selection ignores lock and regulator ready flags
// - range bit picks 1.5-3 MHz reference when 0, 3-5 MHz when 1
// - multiplier code 10=28, 00=20, 11=16, 01=12
// - divider codes 000..110 give main clock as pll clock over code+1
// - divider 111 turns pll off, reference is main clock; reset state
// - halt write 1 enters halt or soft reset; write 0 ignored
// - halt request ignored while halt permit is clear
// - soft reset on halt set gives reset, otherwise halt mode
// - writing 0 to wait bit idles cpu until interrupt acknowledge
// - only hardware returns wait bit to 1, on interrupt acknowledge
// - rtc code 0..9 divides oscillator by 2^(code+1), others stop
// - any change of rtc code restarts the prescaler
module psrc_ctrl import psrc_pkg::*; (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // status from the clock unit
  input  wire logic        PLL_LOCKED_IN,
  input  wire logic        REGULATOR_READY_IN,
  input  wire logic        IRQ_ACK_IN,
  input  wire logic        OSC_CLK_IN,
  // pll control
  output logic             PLL_ENABLE,
  output logic             PLL_FREE_RUN,
  output logic             PLL_REF_RANGE,
  output logic             PLL_REF_HALVE,
  output logic      [4:0]  PLL_MULT,
  output logic      [2:0]  PLL_DIV_CODE,
  output logic             MCLK_FROM_PLL,
  output logic             MCLK_TICK,
  // system modes
  output logic             WFI_IDLE,
  output logic             HALT_MODE,
  output logic             SOFT_RESET_REQ,
  // rtc
  output logic             RTC_CLK_OUT
);

  typedef struct packed {
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           halt_permit;
    logic           soft_reset_on_halt;
    logic           input_halving_bit;
    logic           system_clock_source_select;
    logic           pll_free_run_enable;
    logic           reference_range_select;
    logic [1:0]     pll_multiplier_field;
    logic [2:0]     pll_output_divider_field;
    logic           wait_for_irq_bit;
    logic           halt_bit;
    logic           soft_reset_pulse;
    logic [3:0]     rtc_prescale_field;
    logic [1:0]     lock_sync;
    logic [1:0]     regulator_ready_flag_sync;
    psrc_pll_ctrl_t pll;
  } psrc_state_t;

  psrc_state_t   s_reg;
  psrc_state_t   s_next;
  psrc_apb_req_t req;
  logic          setup;
  logic          wr;
  logic          pll_off;
  logic          locked;
  logic          regulator_ready_flag;

  // address decode shared by read mux and write path
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = reg_hit(addr, OFS_CLOCK_CONTROL_CFG) | reg_hit(addr, OFS_REGULATOR_CONTROL) |
             reg_hit(addr, OFS_CLOCK_FLAGS) | reg_hit(addr, OFS_PLL_CONFIG) |
             reg_hit(addr, OFS_SYSTEM_MODE) | reg_hit(addr, OFS_RTC_PRESCALE);
  endfunction

  function automatic logic [4:0] mult_value(input logic [1:0] code);
    case (code)
      MULT_CODE_X28: mult_value = MULT_X28;
      MULT_CODE_X20: mult_value = MULT_X20;
      MULT_CODE_X16: mult_value = MULT_X16;
      MULT_CODE_X12: mult_value = MULT_X12;
      default:       mult_value = MULT_X20;
    endcase
  endfunction

  assign req     = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};
  assign setup   = req.psel & ~req.penable;
  // writes land on the access edge, when pready is already high
  assign wr      = req.psel & req.penable & req.pwrite & s_reg.pready;
  assign locked  = s_reg.lock_sync[1];
  assign regulator_ready_flag    = s_reg.regulator_ready_flag_sync[1];
  // free run keeps the pll alive even with divider 111
  assign pll_off = (s_reg.pll_output_divider_field == DIV_PLL_OFF) & ~s_reg.pll_free_run_enable;

  always_comb begin
    s_next                  = s_reg;
    s_next.lock_sync        = {s_reg.lock_sync[0], PLL_LOCKED_IN};
    s_next.regulator_ready_flag_sync        = {s_reg.regulator_ready_flag_sync[0], REGULATOR_READY_IN};
    s_next.soft_reset_pulse = 1'b0;
    s_next.pready           = setup;
    s_next.pslverr          = setup & ~mapped(req.paddr);
    s_next.prdata           = 32'h0;

    // read data captured in the setup cycle; unlisted bits stay zero
    if (setup & ~req.pwrite) begin
      if (reg_hit(req.paddr, OFS_CLOCK_CONTROL_CFG)) begin
        s_next.prdata[BIT_HALT_PERMIT]     = s_reg.halt_permit;
        s_next.prdata[BIT_SOFT_RESET_HALT] = s_reg.soft_reset_on_halt;
      end
      if (reg_hit(req.paddr, OFS_REGULATOR_CONTROL)) begin
        s_next.prdata[BIT_REGULATOR_READY] = regulator_ready_flag;
      end
      if (reg_hit(req.paddr, OFS_CLOCK_FLAGS)) begin
        s_next.prdata[BIT_INPUT_HALVING] = s_reg.input_halving_bit;
        s_next.prdata[BIT_PLL_LOCKED]    = locked;
        s_next.prdata[BIT_CLOCK_SOURCE]  = s_reg.system_clock_source_select;
      end
      if (reg_hit(req.paddr, OFS_PLL_CONFIG)) begin
        s_next.prdata[BIT_FREE_RUN]          = s_reg.pll_free_run_enable;
        s_next.prdata[BIT_REF_RANGE]         = s_reg.reference_range_select;
        s_next.prdata[POS_MULT +: 2]         = s_reg.pll_multiplier_field;
        s_next.prdata[POS_DIV +: 3]          = s_reg.pll_output_divider_field;
      end
      if (reg_hit(req.paddr, OFS_SYSTEM_MODE)) begin
        s_next.prdata[BIT_HALT_REQUEST] = s_reg.halt_bit;
        s_next.prdata[BIT_WAIT_FOR_IRQ] = s_reg.wait_for_irq_bit;
      end
      if (reg_hit(req.paddr, OFS_RTC_PRESCALE)) begin
        s_next.prdata[POS_RTC_CODE +: 4] = s_reg.rtc_prescale_field;
      end
    end

    // only documented fields are stored, reserved write data is dropped
    if (wr) begin
      if (reg_hit(req.paddr, OFS_CLOCK_CONTROL_CFG)) begin
        s_next.halt_permit        = req.pwdata[BIT_HALT_PERMIT];
        s_next.soft_reset_on_halt = req.pwdata[BIT_SOFT_RESET_HALT];
      end
      if (reg_hit(req.paddr, OFS_CLOCK_FLAGS)) begin
        s_next.input_halving_bit          = req.pwdata[BIT_INPUT_HALVING];
        s_next.system_clock_source_select = req.pwdata[BIT_CLOCK_SOURCE];
      end
      if (reg_hit(req.paddr, OFS_PLL_CONFIG)) begin
        s_next.pll_free_run_enable      = req.pwdata[BIT_FREE_RUN];
        s_next.reference_range_select   = req.pwdata[BIT_REF_RANGE];
        s_next.pll_multiplier_field     = req.pwdata[POS_MULT +: 2];
        s_next.pll_output_divider_field = req.pwdata[POS_DIV +: 3];
      end
      if (reg_hit(req.paddr, OFS_SYSTEM_MODE)) begin
        if (!req.pwdata[BIT_WAIT_FOR_IRQ]) begin
          s_next.wait_for_irq_bit = 1'b0;
        end
        if (req.pwdata[BIT_HALT_REQUEST] && s_reg.halt_permit) begin
          if (s_reg.soft_reset_on_halt) begin
            s_next.soft_reset_pulse = 1'b1;
          end else begin
            s_next.halt_bit = 1'b1;
          end
        end
      end
      if (reg_hit(req.paddr, OFS_RTC_PRESCALE)) begin
        s_next.rtc_prescale_field = req.pwdata[POS_RTC_CODE +: 4];
      end
    end

    // acknowledge wins over a clear in the same cycle
    if (IRQ_ACK_IN) begin
      s_next.wait_for_irq_bit = 1'b1;
    end

    // source select is held low while the pll is off
    if ((s_next.pll_output_divider_field == DIV_PLL_OFF) && !s_next.pll_free_run_enable) begin
      s_next.system_clock_source_select = 1'b0;
    end

    // registered copies drive the pll outputs
    s_next.pll.pll_enable    = ~pll_off;
    s_next.pll.free_run      = s_reg.pll_free_run_enable;
    s_next.pll.ref_range     = s_reg.reference_range_select;
    s_next.pll.ref_halve     = s_reg.input_halving_bit;
    s_next.pll.mult          = mult_value(s_reg.pll_multiplier_field);
    s_next.pll.div_code      = s_reg.pll_output_divider_field;
    s_next.pll.mclk_from_pll = ~pll_off & s_reg.system_clock_source_select &
                               (s_reg.pll_free_run_enable | (locked & regulator_ready_flag));
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      s_reg                          <= '0;
      s_reg.pll_free_run_enable      <= PLL_CONFIG_RST[BIT_FREE_RUN];
      s_reg.pll_output_divider_field <= PLL_CONFIG_RST[POS_DIV +: 3];
      s_reg.wait_for_irq_bit         <= SYSTEM_MODE_RST[BIT_WAIT_FOR_IRQ];
      s_reg.rtc_prescale_field       <= RTC_PRESCALE_RST[POS_RTC_CODE +: 4];
      s_reg.pll.div_code             <= PLL_CONFIG_RST[POS_DIV +: 3];
      s_reg.pll.mult                 <= MULT_X20;
    end else begin
      s_reg <= s_next;
    end
  end

  // main clock strobe, counted only while the pll is the source
  psrc_mclk_div u_mclk_div (
    .clk      (CORE_CLK),
    .rst_n    (RESET_N),
    .run      (s_reg.pll.mclk_from_pll),
    .div_code (s_reg.pll.div_code),
    .tick     (MCLK_TICK)
  );

  psrc_rtc_presc u_rtc_presc (
    .clk     (CORE_CLK),
    .rst_n   (RESET_N),
    .osc_pin (OSC_CLK_IN),
    .code    (s_reg.rtc_prescale_field),
    .rtc_clk (RTC_CLK_OUT)
  );

  assign PRDATA         = s_reg.prdata;
  assign PREADY         = s_reg.pready;
  assign PSLVERR        = s_reg.pslverr;
  assign PLL_ENABLE     = s_reg.pll.pll_enable;
  assign PLL_FREE_RUN   = s_reg.pll.free_run;
  assign PLL_REF_RANGE  = s_reg.pll.ref_range;
  assign PLL_REF_HALVE  = s_reg.pll.ref_halve;
  assign PLL_MULT       = s_reg.pll.mult;
  assign PLL_DIV_CODE   = s_reg.pll.div_code;
  assign MCLK_FROM_PLL  = s_reg.pll.mclk_from_pll;
  assign WFI_IDLE       = ~s_reg.wait_for_irq_bit;
  assign HALT_MODE      = s_reg.halt_bit;
  assign SOFT_RESET_REQ = s_reg.soft_reset_pulse;

endmodule // psrc_ctrl

//--- bench/psrc_ctrl_props.sv
// concurrent checks on the ports of psrc_ctrl: apb answers, system modes, pll outputs, rtc prescaler
// assumes binding into psrc_ctrl; bus shadows are rebuilt here from completed apb writes
module psrc_ctrl_chk import psrc_pkg::*; (
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        IRQ_ACK_IN,
  // pll and modes
  input wire logic        PLL_ENABLE,
  input wire logic        PLL_FREE_RUN,
  input wire logic        PLL_REF_RANGE,
  input wire logic [4:0]  PLL_MULT,
  input wire logic [2:0]  PLL_DIV_CODE,
  input wire logic        MCLK_FROM_PLL,
  input wire logic        MCLK_TICK,
  input wire logic        WFI_IDLE,
  input wire logic        HALT_MODE,
  input wire logic        SOFT_RESET_REQ,
  input wire logic        RTC_CLK_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  logic        setup, wr, mapped, permit_sh, srst_sh, gap_ok;
  logic [7:0]  pll_sh;
  logic [3:0]  rtc_sh, gap;
  logic [2:0]  last_div;
  logic [4:0]  mult_exp;
  logic [31:0] keep;
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign mapped = PADDR inside {OFS_CLOCK_CONTROL_CFG, OFS_REGULATOR_CONTROL, OFS_CLOCK_FLAGS,
                                OFS_PLL_CONFIG, OFS_SYSTEM_MODE, OFS_RTC_PRESCALE};
  assign mult_exp = (pll_sh[5:4] == 2'h2) ? 5'h1c : (pll_sh[5:4] == 2'h0) ? 5'h14 :
                    (pll_sh[5:4] == 2'h3) ? 5'h10 : 5'h0c;
  always_comb begin
    case (PADDR)
      OFS_PLL_CONFIG:   keep = 32'h0000_00f7;
      OFS_SYSTEM_MODE:  keep = 32'h0000_0003;
      OFS_RTC_PRESCALE: keep = 32'h0000_000f;
      default:          keep = 32'hffff_ffff;
    endcase
  end
  // shadows only follow completed writes, so refused transfers never disturb them
  always_ff @(posedge CORE_CLK) begin
    last_div <= PLL_DIV_CODE;
    gap <= (!RESET_N || MCLK_TICK) ? 4'h1 : gap + 4'h1;
    if (!RESET_N || !MCLK_FROM_PLL || PLL_DIV_CODE != last_div) gap_ok <= 1'b0;
    else if (MCLK_TICK) gap_ok <= 1'b1;
    if (!RESET_N) begin
      pll_sh <= 8'h07;
      rtc_sh <= 4'hf;
      permit_sh <= 1'b0;
      srst_sh <= 1'b0;
    end else if (wr && PADDR == OFS_PLL_CONFIG) pll_sh <= PWDATA[7:0];
    else if (wr && PADDR == OFS_RTC_PRESCALE) rtc_sh <= PWDATA[3:0];
    else if (wr && PADDR == OFS_CLOCK_CONTROL_CFG) begin
      permit_sh <= PWDATA[BIT_HALT_PERMIT];
      srst_sh <= PWDATA[BIT_SOFT_RESET_HALT];
    end
  end
  a_ready_pulse: assert property (setup |=> PREADY && PSLVERR == !$past(mapped) ##1 !PREADY)
    else $error("apb answer wrong");
  a_rsv_zero: assert property (PREADY && !PWRITE |-> (PRDATA & ~keep) == 32'h0)
    else $error("reserved bits not zero");
  a_pll_fields: assert property (wr && PADDR == OFS_PLL_CONFIG |-> ##2 PLL_MULT == mult_exp &&
    PLL_DIV_CODE == pll_sh[2:0] && PLL_FREE_RUN == pll_sh[7] && PLL_REF_RANGE == pll_sh[6])
    else $error("pll outputs do not follow config");
  a_pll_off: assert property (PLL_DIV_CODE == 3'h7 |-> PLL_ENABLE == PLL_FREE_RUN)
    else $error("pll enable wrong for divider 7");
  // a tick seen at an edge was counted against the divider of the cycle before
  a_tick_gap: assert property (MCLK_TICK && gap_ok |-> gap == 4'(last_div) + 4'h1)
    else $error("main clock tick spacing wrong");
  a_halt_ignored: assert property (wr && PADDR == OFS_SYSTEM_MODE && PWDATA[1] && !permit_sh
    |=> !SOFT_RESET_REQ && HALT_MODE == $past(HALT_MODE)) else $error("halt acted without permit");
  a_halt_action: assert property (wr && PADDR == OFS_SYSTEM_MODE && PWDATA[1] && permit_sh
    |=> SOFT_RESET_REQ == srst_sh && (HALT_MODE || srst_sh)) else $error("halt request result wrong");
  a_wfi_enter: assert property (wr && PADDR == OFS_SYSTEM_MODE && !PWDATA[0] && !IRQ_ACK_IN
    |=> WFI_IDLE) else $error("wait mode not entered");
  a_wfi_leave: assert property (IRQ_ACK_IN |=> !WFI_IDLE) else $error("wait mode kept after ack");
  a_wfi_hold: assert property (WFI_IDLE && !IRQ_ACK_IN |=> WFI_IDLE) else $error("wait left early");
  a_rtc_restart: assert property (wr && PADDR == OFS_RTC_PRESCALE && PWDATA[3:0] != rtc_sh
    |-> ##[1:2] !RTC_CLK_OUT) else $error("rtc not restarted");
  a_rtc_stop: assert property (rtc_sh >= RTC_STOP_CODE && $stable(rtc_sh) |-> !RTC_CLK_OUT)
    else $error("rtc runs on stop code");
  c_tick: cover property (MCLK_TICK && gap_ok);
  c_srst: cover property (SOFT_RESET_REQ);
  c_halt: cover property ($rose(HALT_MODE));
  c_rtc: cover property ($rose(RTC_CLK_OUT));
endmodule // psrc_ctrl_chk

bind psrc_ctrl psrc_ctrl_chk psrc_ctrl_chk_inst (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IRQ_ACK_IN(IRQ_ACK_IN), .PLL_ENABLE(PLL_ENABLE), .PLL_FREE_RUN(PLL_FREE_RUN),
  .PLL_REF_RANGE(PLL_REF_RANGE), .PLL_MULT(PLL_MULT), .PLL_DIV_CODE(PLL_DIV_CODE),
  .MCLK_FROM_PLL(MCLK_FROM_PLL), .MCLK_TICK(MCLK_TICK), .WFI_IDLE(WFI_IDLE), .HALT_MODE(HALT_MODE),
  .SOFT_RESET_REQ(SOFT_RESET_REQ), .RTC_CLK_OUT(RTC_CLK_OUT));

//--- bench/psrc_ctrl_tb_top.sv
// self-checking bench for psrc_ctrl: apb registers, pll outputs, system modes, rtc prescaler
// assumes zero-wait apb answers and the checker bound from psrc_ctrl_props.sv
module psrc_ctrl_tb_top;
  import psrc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clk = 1'b0, rst_n, lock, regulator_ready_flag, ack, osc = 1'b0;
  psrc_apb_req_t req;
  logic [31:0]   prdata, d;
  logic          pready, pslverr, pll_en, free_run, ref_range, ref_halve, from_pll, tick;
  logic          wfi_idle, halt, srst, rtc;
  logic [4:0]    mult;
  logic [2:0]    div_code;
  logic [33:0]   exp_q[$];
  logic [33:0]   e;
  int            fails = 0, checked = 0, cyc = 0, oc = 0, seed, i, j, n;
  logic [7:0]    ofs[3] = '{OFS_PLL_CONFIG, OFS_RTC_PRESCALE, OFS_CLOCK_CONTROL_CFG};
  logic [31:0]   msk[3] = '{32'h0000_00f7, 32'h0000_000f, 32'h0000_0808};
  logic [1:0]    mc[4] = '{2'h2, 2'h0, 2'h3, 2'h1};
  logic [4:0]    mx[4] = '{5'h1c, 5'h14, 5'h10, 5'h0c};
  logic [31:0]   hc[3] = '{32'h0, 32'h0000_0808, 32'h0000_0800};

  always #4 clk = ~clk;

  psrc_ctrl psrc_ctrl_inst (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(req.psel), .PENABLE(req.penable),
    .PWRITE(req.pwrite), .PADDR(req.paddr), .PWDATA(req.pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PLL_LOCKED_IN(lock), .REGULATOR_READY_IN(regulator_ready_flag), .IRQ_ACK_IN(ack), .OSC_CLK_IN(osc),
    .PLL_ENABLE(pll_en), .PLL_FREE_RUN(free_run), .PLL_REF_RANGE(ref_range), .PLL_REF_HALVE(ref_halve),
    .PLL_MULT(mult), .PLL_DIV_CODE(div_code), .MCLK_FROM_PLL(from_pll), .MCLK_TICK(tick),
    .WFI_IDLE(wfi_idle), .HALT_MODE(halt), .SOFT_RESET_REQ(srst), .RTC_CLK_OUT(rtc));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("counts: checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one transfer; the expected answer goes to the queue for the monitor
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ex, input logic err);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    exp_q.push_back({wr, err, ex});
    @(posedge clk);
    req.penable <= 1'b1;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    req <= '0;
  endtask

  task settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // cycles between the first two rising edges of the rtc output; with only one, cycles from the start to it; 0 if none
  task rise_gap(output int g);
    int k, m, t0;
    logic p;
    m = 0;
    t0 = 0;
    g = 0;
    p = 1'b1;
    for (k = 0; k < 1000 && m < 2; k++) begin
      @(posedge clk);
      if (p === 1'b0 && rtc === 1'b1) begin
        m++;
        g = k - t0;
        t0 = k;
      end
      p = rtc;
    end
  endtask

  always @(posedge clk) begin
    if (req.psel && req.penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      check(pslverr, e[32]);
      if (!e[33]) check(prdata, e[31:0]);
    end
  end

  // oscillator pin: one toggle every 3 core cycles, period 6
  always @(posedge clk) begin
    oc <= (oc == 2) ? 0 : oc + 1;
    if (oc == 2) osc <= ~osc;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    seed = 70658;
    rst_n = 1'b0;
    req = '0;
    lock = 1'b1;
    regulator_ready_flag = 1'b1;
    ack = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_PLL_CONFIG, '0, 32'h0000_0007, 1'b0);
    apb(1'b0, OFS_SYSTEM_MODE, '0, 32'h0000_0001, 1'b0);
    apb(1'b0, OFS_RTC_PRESCALE, '0, 32'h0000_000f, 1'b0);
    apb(1'b1, 8'h44, 32'hffff_ffff, '0, 1'b1);
    apb(1'b0, 8'h1a, '0, '0, 1'b1);
    for (i = 0; i < 12; i++) begin
      d = $random(seed);
      apb(1'b1, ofs[i % 3], d, '0, 1'b0);
      apb(1'b0, ofs[i % 3], '0, d & msk[i % 3], 1'b0);
    end
    $display("register map done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, OFS_PLL_CONFIG, {26'h0, mc[i], 4'h0}, '0, 1'b0);
      settle(2);
      check(mult, mx[i]);
      check(pll_en, 1'b1);
    end
    apb(1'b1, OFS_CLOCK_FLAGS, 32'h0000_8001, '0, 1'b0);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, OFS_PLL_CONFIG, (i == 7) ? 32'h87 : 32'(i), '0, 1'b0);
      lock <= (i != 7);
      regulator_ready_flag <= (i != 7);
      settle(8);
      n = 0;
      repeat (840) begin
        @(posedge clk);
        n += (tick === 1'b1);
      end
      check(n, 840 / (i + 1));
    end
    check(from_pll, 1'b1);
    check(ref_halve, 1'b1);
    apb(1'b0, OFS_CLOCK_FLAGS, '0, 32'h0000_8001, 1'b0);
    apb(1'b1, OFS_PLL_CONFIG, 32'h0, '0, 1'b0);
    settle(8);
    check(from_pll, 1'b0);
    $display("pll done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, OFS_RTC_PRESCALE, (i == 3) ? 32'ha : 32'(i), '0, 1'b0);
      rise_gap(n);
      check(n, (i == 3) ? 0 : 12 << i);
    end
    $display("rtc done");
    apb(1'b1, OFS_SYSTEM_MODE, 32'h0, '0, 1'b0);
    settle(1);
    check(wfi_idle, 1'b1);
    apb(1'b1, OFS_SYSTEM_MODE, 32'h1, '0, 1'b0);
    apb(1'b0, OFS_SYSTEM_MODE, '0, 32'h0, 1'b0);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    apb(1'b0, OFS_SYSTEM_MODE, '0, 32'h1, 1'b0);
    check(wfi_idle, 1'b0);
    for (j = 0; j < 3; j++) begin
      apb(1'b1, OFS_CLOCK_CONTROL_CFG, hc[j], '0, 1'b0);
      apb(1'b1, OFS_SYSTEM_MODE, 32'h3, '0, 1'b0);
      #1;
      check(srst, j == 1);
      check(halt, j == 2);
    end
    apb(1'b0, OFS_SYSTEM_MODE, '0, 32'h3, 1'b0);
    $display("system mode done");
    wrap_up();
  end
endmodule // psrc_ctrl_tb_top
